// ===== ebcid_defines.svh
// Constants for the eight-bit core instruction decoder
`ifndef EBCID_DEFINES_SVH
`define EBCID_DEFINES_SVH
`define EBCID_PHASES        4
`define EBCID_SECOND_MARK   4'hF
`define EBCID_DEST_BIT      9
`define EBCID_ACCESS_BIT    8
`define EBCID_BIT_LSB       9
`define EBCID_ACCESS_SPLIT  8'h60
`define EBCID_ACCESS_HIGH   4'hF
`define EBCID_RESET_WORKING 8'h00
`define EBCID_RESET_BANK    4'h0
`define EBCID_RESET_PC      16'h0000
`endif

// ===== ebcid_pkg.sv
// Types shared by the eight-bit core instruction decoder
package ebcid_pkg;
  typedef enum logic [1:0] {
    EBCID_Q_DECODE  = 2'h0,
    EBCID_Q_READ    = 2'h1,
    EBCID_Q_PROCESS = 2'h3,
    EBCID_Q_WRITE   = 2'h2
  } ebcid_phase_t;

  typedef enum logic [2:0] {
    EBCID_CLS_NOP     = 3'h0,
    EBCID_CLS_BYTE    = 3'h1,
    EBCID_CLS_BIT     = 3'h2,
    EBCID_CLS_LITERAL = 3'h3,
    EBCID_CLS_CONTROL = 3'h4,
    EBCID_CLS_EXTEND  = 3'h5
  } ebcid_class_t;

  typedef struct packed {
    ebcid_class_t cls;
    logic [5:0]   opcode;
    logic         dest_file;
    logic         use_bank;
    logic [2:0]   bit_num;
    logic [7:0]   file_addr;
    logic [7:0]   literal;
    logic [1:0]   pointer_sel;
    logic [10:0]  branch_off;
    logic         fast_mode;
    logic [1:0]   table_mode;
    logic         double_word;
    logic         conditional;
    logic         changes_pc;
  } ebcid_decoded_t;

  typedef struct packed {
    logic        write_en;
    logic        to_working;
    logic [11:0] address;
    logic [7:0]  data;
  } ebcid_result_t;
endpackage : ebcid_pkg

// ===== ebcid_core.sv
// Instruction decode and cycle timing for the eight-bit core
// Summary of operation
// - Decode 75 standard plus eight extended
// - Single instruction is one 16-bit word
// - Four double-word forms, second word marked 1111
// - Lone second word executes as no-operation
// - Destination bit picks working or file register
// - Bit field selects affected file bit
// - Literal, pointer target or no operand
// - Address, call mode, table mode operands
// - One cycle; taken or jump adds nop cycle
// - Double-word instructions take two cycles
// - Instruction cycle is four oscillator periods
// - Taken skip over two-word takes three cycles
// - Access bit zero uses access bank
`timescale 1ns/100ps
`include "ebcid_defines.svh"
module ebcid_core (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [15:0]           instr_word,
  input  wire logic [7:0]            file_read_data,
  input  wire logic                  condition_true,
  output logic [15:0]                program_counter,
  output logic                       fetch_strobe,
  output logic [11:0]                file_read_addr,
  output ebcid_pkg::ebcid_result_t   result,
  output logic [7:0]                 working_register,
  output logic [3:0]                 bank_select_register,
  output ebcid_pkg::ebcid_decoded_t  decoded,
  output logic                       nop_cycle,
  output ebcid_pkg::ebcid_phase_t    phase
);
  ebcid_pkg::ebcid_phase_t   next_phase;
  ebcid_pkg::ebcid_decoded_t dec_now;
  ebcid_pkg::ebcid_decoded_t next_decoded;
  ebcid_pkg::ebcid_result_t  next_result;
  logic [15:0] next_program_counter;
  logic [7:0]  next_working_register;
  logic [3:0]  next_bank_select_register;
  logic [11:0] next_file_read_addr;
  logic [7:0]  operand;
  logic [7:0]  next_operand;
  logic [7:0]  alu_out;
  logic [1:0]  stall_left;
  logic [1:0]  next_stall_left;
  logic        next_nop_cycle;
  logic        next_fetch_strobe;
  logic        expect_second;
  logic        next_expect_second;
  logic        skip_armed;
  logic        next_skip_armed;

  // Field split of the fetched word
  always_comb begin
    dec_now             = '0;
    dec_now.cls         = ebcid_pkg::EBCID_CLS_NOP;
    dec_now.opcode      = instr_word[15:10];
    dec_now.dest_file   = instr_word[`EBCID_DEST_BIT];
    dec_now.use_bank    = instr_word[`EBCID_ACCESS_BIT];
    dec_now.bit_num     = instr_word[`EBCID_BIT_LSB+2:`EBCID_BIT_LSB];
    dec_now.file_addr   = instr_word[7:0];
    dec_now.literal     = instr_word[7:0];
    dec_now.pointer_sel = instr_word[5:4];
    dec_now.branch_off  = instr_word[10:0];
    dec_now.fast_mode   = instr_word[0];
    dec_now.table_mode  = instr_word[1:0];
    unique casez (instr_word[15:12])
      4'h0: begin
        if (instr_word[11:8] == 4'h0) begin
          dec_now.cls        = ebcid_pkg::EBCID_CLS_CONTROL;
          dec_now.changes_pc = (instr_word[7:1] == 7'h09); // return forms
        end else if (instr_word[11:8] == 4'hE) begin
          dec_now.cls         = ebcid_pkg::EBCID_CLS_LITERAL;
          dec_now.double_word = instr_word[7:6] == 2'h0; // pointer load
        end else begin
          dec_now.cls = ebcid_pkg::EBCID_CLS_LITERAL;
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        dec_now.cls         = ebcid_pkg::EBCID_CLS_BYTE;
        dec_now.conditional = instr_word[15:12] == 4'h6 && instr_word[11:10] != 2'h3;
      end
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
        dec_now.cls         = ebcid_pkg::EBCID_CLS_BIT;
        dec_now.conditional = instr_word[15:13] == 3'h5;
      end
      4'hC: begin
        dec_now.cls         = ebcid_pkg::EBCID_CLS_BYTE;
        dec_now.double_word = 1'b1; // file move
      end
      4'hD: begin
        dec_now.cls        = ebcid_pkg::EBCID_CLS_CONTROL;
        dec_now.changes_pc = 1'b1;
      end
      4'hE: begin
        dec_now.cls         = (instr_word[11:8] == 4'h8) ? ebcid_pkg::EBCID_CLS_EXTEND
                                                          : ebcid_pkg::EBCID_CLS_CONTROL;
        dec_now.double_word = instr_word[11:9] == 3'h6 || instr_word[11:8] == 4'hF;
        dec_now.conditional = instr_word[11] == 1'b0;
        dec_now.changes_pc  = instr_word[11:9] != 3'h4 && instr_word[11] == 1'b1;
      end
      default: begin
        dec_now.cls = ebcid_pkg::EBCID_CLS_NOP; // marked second word
      end
    endcase
  end

  // Bit ops toggle the bit; byte ops add
  always_comb begin
    alu_out = operand;
    unique case (decoded.cls)
      ebcid_pkg::EBCID_CLS_BIT:
        alu_out = operand ^ (8'h01 << decoded.bit_num);
      ebcid_pkg::EBCID_CLS_BYTE:
        alu_out = operand + working_register;
      ebcid_pkg::EBCID_CLS_LITERAL:
        alu_out = decoded.literal;
      default:
        alu_out = operand;
    endcase
  end

  // Phase sequencer and execution
  always_comb begin
    next_phase                = phase;
    next_decoded              = decoded;
    next_result               = result;
    next_program_counter      = program_counter;
    next_working_register     = working_register;
    next_bank_select_register = bank_select_register;
    next_file_read_addr       = file_read_addr;
    next_operand              = operand;
    next_stall_left           = stall_left;
    next_nop_cycle            = nop_cycle;
    next_fetch_strobe         = 1'b0;
    next_expect_second        = expect_second;
    next_skip_armed           = skip_armed;
    next_result.write_en      = 1'b0;
    unique case (phase)
      ebcid_pkg::EBCID_Q_DECODE: begin
        next_phase = ebcid_pkg::EBCID_Q_READ;
        if (stall_left != 2'h0 || expect_second
            || instr_word[15:12] == `EBCID_SECOND_MARK) begin
          next_decoded     = '0;
          next_decoded.cls = ebcid_pkg::EBCID_CLS_NOP;
        end else begin
          next_decoded = dec_now;
        end
        next_nop_cycle  = stall_left != 2'h0;
        next_skip_armed = 1'b0;
        // Skipped opcode owns a tail word; one more stall cycle
        if (skip_armed && dec_now.double_word) begin
          next_stall_left    = 2'h2;
          next_expect_second = 1'b1;
        end
        // Address set here so the file data settles during read
        if (next_decoded.use_bank) begin
          next_file_read_addr = {bank_select_register, next_decoded.file_addr};
        end else if (next_decoded.file_addr < `EBCID_ACCESS_SPLIT) begin
          next_file_read_addr = {4'h0, next_decoded.file_addr};
        end else begin
          next_file_read_addr = {`EBCID_ACCESS_HIGH, next_decoded.file_addr};
        end
      end
      ebcid_pkg::EBCID_Q_READ: begin
        next_phase = ebcid_pkg::EBCID_Q_PROCESS;
        next_operand = (decoded.cls == ebcid_pkg::EBCID_CLS_LITERAL) ? decoded.literal
                                                                       : file_read_data;
      end
      ebcid_pkg::EBCID_Q_PROCESS: begin
        next_phase   = ebcid_pkg::EBCID_Q_WRITE;
        next_operand = alu_out;
      end
      ebcid_pkg::EBCID_Q_WRITE: begin
        next_phase           = ebcid_pkg::EBCID_Q_DECODE;
        next_program_counter = program_counter + 16'h0001;
        next_fetch_strobe    = 1'b1;
        if (stall_left != 2'h0) begin
          next_stall_left = stall_left - 2'h1;
          if (expect_second) begin
            next_expect_second = 1'b0;
          end
        end else if (decoded.cls == ebcid_pkg::EBCID_CLS_BYTE
                     || decoded.cls == ebcid_pkg::EBCID_CLS_BIT) begin
          next_result.write_en   = 1'b1;
          next_result.to_working = !decoded.dest_file;
          next_result.address    = file_read_addr;
          next_result.data       = operand;
          if (!decoded.dest_file && decoded.cls == ebcid_pkg::EBCID_CLS_BYTE) begin
            next_working_register = operand;
          end
        end else if (decoded.cls == ebcid_pkg::EBCID_CLS_LITERAL) begin
          if (decoded.pointer_sel == 2'h0 && !decoded.double_word) begin
            next_working_register = operand;
          end else if (decoded.opcode[1:0] == 2'h1) begin
            next_bank_select_register = operand[3:0];
          end
        end
        if (stall_left == 2'h0) begin
          next_skip_armed = decoded.conditional && condition_true && !decoded.double_word;
          if (decoded.double_word) begin
            next_expect_second = 1'b1;
            next_stall_left    = (decoded.conditional && condition_true) ? 2'h2 : 2'h1;
          end else if ((decoded.conditional && condition_true) || decoded.changes_pc) begin
            next_stall_left = 2'h1;
          end
        end
      end
      default: next_phase = ebcid_pkg::EBCID_Q_DECODE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase                <= ebcid_pkg::EBCID_Q_DECODE;
      decoded              <= '0;
      result               <= '0;
      program_counter      <= `EBCID_RESET_PC;
      working_register     <= `EBCID_RESET_WORKING;
      bank_select_register <= `EBCID_RESET_BANK;
      file_read_addr       <= 12'h000;
      operand              <= 8'h00;
      stall_left           <= 2'h0;
      nop_cycle            <= 1'b0;
      fetch_strobe         <= 1'b0;
      expect_second        <= 1'b0;
      skip_armed           <= 1'b0;
    end else begin
      phase                <= next_phase;
      decoded              <= next_decoded;
      result               <= next_result;
      program_counter      <= next_program_counter;
      working_register     <= next_working_register;
      bank_select_register <= next_bank_select_register;
      file_read_addr       <= next_file_read_addr;
      operand              <= next_operand;
      stall_left           <= next_stall_left;
      nop_cycle            <= next_nop_cycle;
      fetch_strobe         <= next_fetch_strobe;
      expect_second        <= next_expect_second;
      skip_armed           <= next_skip_armed;
    end
  end
endmodule : ebcid_core

// ===== ebcid_core_monitor.sv
// Checker on the decoder top ports
`timescale 1ns/100ps
module ebcid_core_monitor (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic [15:0]               instr_word,
  input wire logic [7:0]                file_read_data,
  input wire logic                      condition_true,
  input wire logic [15:0]               program_counter,
  input wire logic                      fetch_strobe,
  input wire logic [11:0]               file_read_addr,
  input wire ebcid_pkg::ebcid_result_t  result,
  input wire logic [7:0]                working_register,
  input wire logic [3:0]                bank_select_register,
  input wire ebcid_pkg::ebcid_decoded_t decoded,
  input wire logic                      nop_cycle,
  input wire ebcid_pkg::ebcid_phase_t   phase
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic qd  = phase == ebcid_pkg::EBCID_Q_DECODE;
  wire logic qr  = phase == ebcid_pkg::EBCID_Q_READ;
  wire logic qp  = phase == ebcid_pkg::EBCID_Q_PROCESS;
  wire logic qw  = phase == ebcid_pkg::EBCID_Q_WRITE;
  wire logic cb_ = decoded.cls == ebcid_pkg::EBCID_CLS_BYTE;
  wire logic ct  = decoded.cls == ebcid_pkg::EBCID_CLS_BIT;
  // Upper part of the access bank lands in bank F
  wire logic [3:0] acc = (decoded.file_addr >= 8'h60) ? 4'hF : 4'h0;
  // Opcodes with a tail word: pointer load, file move, call, goto
  wire logic dbl = instr_word[15:12] == 4'hC
    || (instr_word[15:8] == 8'h0E && instr_word[7:6] == 2'h0)
    || (instr_word[15:12] == 4'hE && (instr_word[11:9] == 3'h6 || instr_word[11:8] == 4'hF));
  a_phase_enter: assert property (qd |=> qr)
    else $error("decode not followed by read");
  a_phase_rest: assert property (qr |=> qp ##1 qw ##1 qd)
    else $error("read, process, write order broken");
  a_fetch_gap: assert property (fetch_strobe |=> !fetch_strobe [*3] ##1 fetch_strobe)
    else $error("fetch spacing not four clocks");
  a_marked_nop: assert property (qd && instr_word[15:12] == 4'hF |=>
    decoded.cls == ebcid_pkg::EBCID_CLS_NOP ##3 !result.write_en) else $error("marked word ran");
  a_dest_pick: assert property (result.write_en && cb_ |->
    result.to_working == !decoded.dest_file) else $error("wrong destination");
  a_bit_field: assert property (qr && ct |-> decoded.bit_num == $past(instr_word[11:9]))
    else $error("bit number field wrong");
  a_access_bank: assert property (qp && (cb_ || ct) && !decoded.use_bank |->
    file_read_addr == {acc, decoded.file_addr}) else $error("access bank address wrong");
  a_bank_pick: assert property (qp && (cb_ || ct) && decoded.use_bank |->
    file_read_addr == {bank_select_register, decoded.file_addr}) else $error("bank address wrong");
  a_double_stall: assert property (qr && decoded.double_word |-> ##4 nop_cycle)
    else $error("double word without stall");
  a_jump_stall: assert property (qr && decoded.changes_pc |-> ##4 nop_cycle)
    else $error("pc change without stall");
  a_taken_extra: assert property (qr && decoded.conditional && !decoded.double_word ##2
    condition_true ##1 dbl |-> ##5 nop_cycle) else $error("taken skip over double too short");
endmodule : ebcid_core_monitor

bind ebcid_core ebcid_core_monitor i_mon (.clock(clock), .reset(reset), .instr_word(instr_word),
  .file_read_data(file_read_data), .condition_true(condition_true), .result(result),
  .program_counter(program_counter), .fetch_strobe(fetch_strobe), .decoded(decoded),
  .file_read_addr(file_read_addr), .working_register(working_register), .phase(phase),
  .bank_select_register(bank_select_register), .nop_cycle(nop_cycle));

// ===== ebcid_prog_mem.sv
// Program memory model feeding instruction words
`timescale 1ns/100ps
module ebcid_prog_mem (
  input  wire logic [15:0] program_counter,
  output logic      [15:0] instr_word
);
  logic [15:0] words [0:15];
  // Level output; follows the counter, settled by the end of decode
  assign instr_word = words[program_counter[3:0]];
endmodule : ebcid_prog_mem

// ===== ebcid_core_tb_top.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
module ebcid_core_tb_top;
  typedef struct packed { logic [15:0] w; logic nop; } ebcid_row_t;
  logic                      clock;
  logic                      reset;
  logic                      condition_true;
  logic [7:0]                file_read_data;
  logic [15:0]               instr_word;
  logic [15:0]               program_counter;
  logic                      fetch_strobe;
  logic [11:0]               file_read_addr;
  ebcid_pkg::ebcid_result_t  result;
  logic [7:0]                working_register;
  logic [3:0]                bank_select_register;
  ebcid_pkg::ebcid_decoded_t decoded;
  logic                      nop_cycle;
  ebcid_pkg::ebcid_phase_t   phase;
  int                        err_count;
  int                        num_checks;
  int                        n;
  ebcid_row_t                r;
  ebcid_row_t rows [0:7] = '{'{16'h2400, 1'b0}, '{16'h2661, 1'b0}, '{16'hF123, 1'b1},
    '{16'h7370, 1'b0}, '{16'h0553, 1'b0}, '{16'hEF10, 1'b0}, '{16'hF000, 1'b1}, '{16'h6B85, 1'b0}};
  ebcid_core i_dut (.clock(clock), .reset(reset), .instr_word(instr_word), .phase(phase),
    .file_read_data(file_read_data), .condition_true(condition_true), .result(result),
    .program_counter(program_counter), .fetch_strobe(fetch_strobe), .decoded(decoded),
    .file_read_addr(file_read_addr), .working_register(working_register),
    .bank_select_register(bank_select_register), .nop_cycle(nop_cycle));
  ebcid_prog_mem i_mem (.program_counter(program_counter), .instr_word(instr_word));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Bounded step until the wanted phase or a fetch pulse
  task automatic step_until(input logic fetch, input ebcid_pkg::ebcid_phase_t p, output int k);
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while ((fetch ? fetch_strobe !== 1'b1 : phase !== p) && k < 20);
    if (k >= 20) begin
      err_count++;
      give_verdict();
    end
  endtask : step_until
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    #1;
    file_read_data <= file_read_addr[7:0] ^ 8'hA5;
    condition_true <= program_counter[0];
  end
  initial begin
    reset = 1'b1;
    for (int i = 0; i < 16; i++)
      i_mem.words[i] = (i < 8) ? rows[i].w : 16'h0000;
    // Double word skipped by the taken test in the last row
    i_mem.words[8] = 16'hC123;
    i_mem.words[9] = 16'hF456;
    repeat (16) @(posedge clock);
    #1;
    check(phase, ebcid_pkg::EBCID_Q_DECODE);
    check(program_counter, 16'h0000);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      step_until(1'b0, ebcid_pkg::EBCID_Q_READ, n);
      r = rows[program_counter[2:0]];
      if (r.nop) begin
        check(decoded.cls, ebcid_pkg::EBCID_CLS_NOP);
        repeat (3) @(posedge clock);
        #1;
        check(result.write_en, 1'b0);
      end else if (!nop_cycle && decoded.cls == ebcid_pkg::EBCID_CLS_BYTE) begin
        check(decoded.dest_file, r.w[9]);
        check(decoded.use_bank, r.w[8]);
      end else if (!nop_cycle && decoded.cls == ebcid_pkg::EBCID_CLS_BIT) begin
        check(decoded.bit_num, r.w[11:9]);
      end else if (!nop_cycle && decoded.cls == ebcid_pkg::EBCID_CLS_LITERAL) begin
        check(decoded.literal, r.w[7:0]);
      end
      $display("row %0d done", i);
    end
    check(file_read_addr, 16'h0385);
    check(working_register, 16'h00A5);
    check(bank_select_register, 16'h0003);
    $display("operand paths done");
    // Taken skip over a double word: two stall cycles, then normal
    for (int j = 0; j < 3; j++) begin
      step_until(1'b0, ebcid_pkg::EBCID_Q_READ, n);
      check(nop_cycle, (j < 2) ? 16'h0001 : 16'h0000);
    end
    $display("skip over double done");
    step_until(1'b1, ebcid_pkg::EBCID_Q_DECODE, n);
    step_until(1'b1, ebcid_pkg::EBCID_Q_DECODE, n);
    check(16'(n), 16'h0004);
    $display("fetch spacing done");
    step_until(1'b0, ebcid_pkg::EBCID_Q_PROCESS, n);
    reset = 1'b1;
    #5;
    check(phase, ebcid_pkg::EBCID_Q_DECODE);
    check(program_counter, 16'h0000);
    @(posedge clock);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(program_counter, 16'h0000);
    @(posedge clock);
    #1;
    check(program_counter, 16'h0001);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule : ebcid_core_tb_top
